// ### verification/board_model.sv
`timescale 1ns/1ps
module board_model (
  input wire clk,
  input wire [1:0] sleep_cmd,
  input wire sess_cmd,
  input wire [7:0] pin_cmd,
  output reg sleep_a,
  output reg sleep_b,
  output reg prog_session,
  output reg [7:0] pin_in,
  output reg [3:0] jtag_pin
);
  // ----
  // board pins
  // ----
  initial {sleep_a, sleep_b, prog_session, pin_in, jtag_pin} = 0;
  always @(posedge clk) begin
    {sleep_b, sleep_a} <= sleep_cmd;
    prog_session <= sess_cmd;
    pin_in <= pin_cmd;
    jtag_pin <= pin_cmd[7:4];
  end
endmodule // board_model

// ### verification/pwr_chk.sv
`timescale 1ns/1ps
module pwr_chk #(
  parameter PINS = 8
) (
  input wire CLK,
  input wire SYS_RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PREADY,
  input wire PSLVERR,
  input wire SLEEP_REQUEST_A,
  input wire SLEEP_REQUEST_B,
  input wire [PINS-1:0] PIN_OUT,
  input wire [PINS-1:0] PIN_OE,
  input wire [PINS-1:0] CORE_IN,
  input wire [PINS-1:0] SLEW_FAST,
  input wire JTAG_PORT_ENABLED,
  input wire POWERED_DOWN
);
  // ----
  // checks
  // ----
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence quiet_s;
    !SLEEP_REQUEST_A && !SLEEP_REQUEST_B;
  endsequence
  sequence held_s;
    POWERED_DOWN && $past(POWERED_DOWN);
  endsequence
  ready_high_a: assert property (PREADY) else $error("pready low");
  err_access_a: assert property (PSLVERR |-> PSEL && PENABLE) else $error("stray error");
  hold_out_a: assert property (held_s |-> $stable(PIN_OUT)) else $error("out moved");
  hold_oe_a: assert property (held_s |-> $stable(PIN_OE)) else $error("oe moved");
  hold_in_a: assert property (held_s |-> $stable(CORE_IN)) else $error("in moved");
  sleep_idle_a: assert property (quiet_s [*8] |-> !POWERED_DOWN) else $error("stuck down");
  reset_val_a: assert property ($fell(SYS_RST) |-> SLEW_FAST == '0 && JTAG_PORT_ENABLED)
    else $error("bad reset value");
  init_pins_a: assert property ($fell(SYS_RST) |-> ##3 (&PIN_OE && PIN_OUT == '0) [*5])
    else $error("bad init pins");
endmodule // pwr_chk
bind power_config_ctrl pwr_chk #(.PINS(PINS)) pwr_chk_inst (.*);

// ### verification/tb_top.sv
`timescale 1ns/1ps
`include "pwr_cfg_consts.vh"
module tb_top;
  reg CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, sess_cmd = 0;
  reg [7:0] PADDR = 0, CORE_OUT = 0, CORE_OE = 0, pin_cmd = 0;
  reg [31:0] PWDATA = 0, rnd = 32'h141e_d346;
  reg [1:0] sleep_cmd = 0;
  wire [31:0] PRDATA, CELL_REDUCED_POWER;
  wire PREADY, PSLVERR, SLEEP_REQUEST_A, SLEEP_REQUEST_B, PROG_SESSION;
  wire HYST_LARGE, JTAG_PORT_ENABLED, POWERED_DOWN, KEEPER_ACTIVE;
  wire [3:0] JTAG_PIN_IN, JTAG_USER_IN;
  wire [7:0] PIN_IN, CORE_IN, PIN_OUT, PIN_OE, SLEW_FAST;
  integer n_mismatch = 0, checks = 0;
  reg [31:0] expq[$];
  power_config_ctrl power_config_ctrl_inst (.*);
  board_model board_model_inst (.clk(CLK), .sleep_cmd(sleep_cmd), .sess_cmd(sess_cmd),
    .pin_cmd(pin_cmd), .sleep_a(SLEEP_REQUEST_A), .sleep_b(SLEEP_REQUEST_B),
    .prog_session(PROG_SESSION), .pin_in(PIN_IN), .jtag_pin(JTAG_PIN_IN));
  // ----
  // helpers
  // ----
  initial forever #20 CLK = ~CLK;
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected %s exp %h got %h", nm, exp, seen);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge CLK) {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
    @(posedge CLK) PENABLE <= 1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    {PSEL, PENABLE} <= 2'b00;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    expq.push_back(e);
    apb(0, a, 0);
  endtask
  task summarize;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge CLK) begin
    if (PSEL && PENABLE && !PWRITE && PREADY) chk("prdata", PRDATA, expq.pop_front());
    if (PSEL && PENABLE) chk("pslverr", PSLVERR, PADDR > `OFS_OUT_POLARITY);
  end
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    summarize;
  end
  // ----
  // scenarios
  // ----
  initial begin
    repeat (16) @(posedge CLK);
    SYS_RST <= 0;
    repeat (12) @(posedge CLK);
    rd(`OFS_CTRL, `CTRL_RESET);
    rd(`OFS_STATUS, 32'h0000_0018);
    rd(`OFS_SLEW_FAST, `SLEW_RESET);
    rd(8'h20, 32'h0000_0000);
    @(posedge CLK) sleep_cmd <= 2'b01;
    repeat (12) @(negedge CLK);
    chk("off", POWERED_DOWN, 0);
    @(posedge CLK) sleep_cmd <= 0;
    rnd = lfsr(rnd);
    apb(1, `OFS_SLEW_FAST, {24'h0, rnd[7:0]});
    apb(1, `OFS_REDUCED_POWER, rnd);
    apb(1, `OFS_CTRL, 32'h0000_0007);
    @(posedge CLK);
    @(negedge CLK) chk("slew", SLEW_FAST, rnd[7:0]);
    chk("cells", CELL_REDUCED_POWER, rnd);
    chk("hyst", HYST_LARGE, 1);
    rd(`OFS_SLEW_FAST, {24'h0, rnd[7:0]});
    apb(1, `OFS_OUT_POLARITY, {24'h0, rnd[23:16]});
    rd(`OFS_OUT_POLARITY, {24'h0, rnd[23:16]});
    @(posedge CLK) {CORE_OUT, CORE_OE, pin_cmd} <= {16'ha5f0, rnd[15:8]};
    repeat (15) @(posedge CLK);
    sleep_cmd <= 2'b10;
    repeat (20) if (POWERED_DOWN !== 1'b1) @(negedge CLK);
    chk("down", POWERED_DOWN, 1);
    @(posedge CLK) {CORE_OUT, CORE_OE, pin_cmd} <= {16'h5a0f, ~pin_cmd};
    repeat (10) @(negedge CLK);
    chk("hold", PIN_OUT, 8'ha5);
    chk("hold oe", PIN_OE, 8'hf0);
    chk("block", CORE_IN, rnd[15:8] & 8'hfe);
    @(posedge CLK) sleep_cmd <= 0;
    repeat (20) if (POWERED_DOWN !== 1'b0) @(negedge CLK);
    chk("up", POWERED_DOWN, 0);
    repeat (6) @(negedge CLK);
    chk("resume", CORE_IN, pin_cmd & 8'hfe);
    apb(1, `OFS_CTRL, 32'h0000_0000);
    repeat (6) @(negedge CLK);
    chk("jtag", JTAG_PORT_ENABLED, 0);
    chk("juser", JTAG_USER_IN, pin_cmd[7:4]);
    @(posedge CLK) sess_cmd <= 1;
    repeat (8) @(posedge CLK);
    apb(1, `OFS_CTRL, 32'h0000_0004);
    apb(1, `OFS_PROG_CTRL, 32'h0000_0001);
    apb(1, `OFS_SIGNATURE, 32'h0000_1234);
    apb(1, `OFS_CONFIG_DATA, rnd);
    apb(1, `OFS_PROG_CTRL, 32'h0000_0010);
    rd(`OFS_CONFIG_DATA, rnd);
    apb(1, `OFS_PROG_CTRL, 32'h0000_0014);
    rd(`OFS_CONFIG_DATA, 32'h0000_0000);
    rd(`OFS_SIGNATURE, 32'h0000_1234);
    apb(1, `OFS_PROG_CTRL, 32'h0000_0018);
    rd(`OFS_STATUS, 32'h0000_0038);
    apb(1, `OFS_PROG_CTRL, 32'h0000_0002);
    apb(1, `OFS_CTRL, 32'h0000_000c);
    apb(1, `OFS_PROG_CTRL, 32'h0000_0001);
    @(posedge CLK);
    @(negedge CLK) chk("keep", KEEPER_ACTIVE, 1);
    chk("keep oe", PIN_OE, 8'h0f);
    @(posedge CLK) sess_cmd <= 0;
    repeat (12) @(negedge CLK);
    chk("lock oe", PIN_OE, 0);
    summarize;
  end
endmodule // tb_top

// ### verilog/power_config_ctrl.v
// Functional notes
// R1 - power-down option set: either sleep request pin high enters power-down
// R2 - power-down latches internal state and enabled outputs at entry values
// R3 - pin transitions ignored until active sleep request pin goes low
// R4 - sleep pins not logic inputs; their macrocells stay usable internally
// R5 - each macrocell has its own reduced-power setting, unused ones off
// R6 - each output has own slew setting, slow by default
// R7 - shortly after power-up reset registers initialize, outputs follow polarity
// R8 - driver meets setup times before raising clock after reset
// R9 - clock stays stable throughout power-up reset
// R10 - power-up reset hysteresis selectable small or large
// R11 - programmed security fuse blocks configuration readback
// R12 - 16-bit user signature readable regardless of fuse
// R13 - programming runs over four-signal JTAG port driven by programmer
// R14 - JTAG port can be disabled, its four pins become user I/O
// R15 - interrupted programming locks device, pins held high impedance
// R16 - pin keeper option holds pins at former level during programming
// R17 - device starts in erased configuration, ready for programming
// R18 - outputs high impedance at power-down entry stay so throughout
// R19 - both sleep pins low releases hold, resumes from held values
`timescale 1ns/1ps
`include "pwr_cfg_consts.vh"
module power_config_ctrl #(
  parameter PINS = 8,
  parameter CELLS = 32,
  parameter CFG_WORDS = 8,
  parameter PTR_W = 3
) (
  input wire CLK,
  input wire SYS_RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire SLEEP_REQUEST_A,
  input wire SLEEP_REQUEST_B,
  input wire PROG_SESSION,
  input wire [3:0] JTAG_PIN_IN,
  input wire [PINS-1:0] PIN_IN,
  output reg [PINS-1:0] CORE_IN,
  output reg [3:0] JTAG_USER_IN,
  input wire [PINS-1:0] CORE_OUT,
  input wire [PINS-1:0] CORE_OE,
  output reg [PINS-1:0] PIN_OUT,
  output reg [PINS-1:0] PIN_OE,
  output reg [CELLS-1:0] CELL_REDUCED_POWER,
  output reg [PINS-1:0] SLEW_FAST,
  output reg HYST_LARGE,
  output reg JTAG_PORT_ENABLED,
  output reg POWERED_DOWN,
  output reg KEEPER_ACTIVE
);
  localparam INIT_CYCLES_RAW = (`INIT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam INIT_CYCLES = (INIT_CYCLES_RAW < 1) ? 1 : INIT_CYCLES_RAW;
  localparam [31:0] INIT_SPAN = INIT_CYCLES - 1;
  localparam [7:0] INIT_LAST = INIT_SPAN[7:0];
  localparam PH_INIT = 2'd0;
  localparam PH_RUN = 2'd1;
  localparam PH_DOWN = 2'd2;
  localparam [31:0] SLEW_INIT = `SLEW_RESET;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [PINS+5:0] filt;
    input [PINS+5:0] s2;
    input [PINS+5:0] s3;
    input [PINS+5:0] prev;
    begin
      filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & prev);
    end
  endfunction

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [PINS+5:0] s1;
  reg [PINS+5:0] s2;
  reg [PINS+5:0] s3;
  reg [PINS+5:0] clean;
  always @(posedge CLK) begin
    if (SYS_RST) begin
      s1 <= {(PINS+6){1'b0}};
      s2 <= {(PINS+6){1'b0}};
      s3 <= {(PINS+6){1'b0}};
      clean <= {(PINS+6){1'b0}};
    end else begin
      s1 <= {JTAG_PIN_IN, PROG_SESSION, SLEEP_REQUEST_B, SLEEP_REQUEST_A, PIN_IN[PINS-1:1]};
      s2 <= s1;
      s3 <= s2;
      clean <= filt(s2, s3, clean);
    end
  end
  wire [PINS-1:0] pin_clean = {clean[PINS-2:0], 1'b0};
  wire sleep_a = clean[PINS-1];
  wire sleep_b = clean[PINS];
  wire session = clean[PINS+1];
  wire [3:0] jtag_clean = clean[PINS+5:PINS+2];
  reg [PINS-1:0] pin0_s;
  reg pin0_clean;
  always @(posedge CLK) begin
    if (SYS_RST) begin
      pin0_s <= {PINS{1'b0}};
      pin0_clean <= 1'b0;
    end else begin
      pin0_s <= {pin0_s[PINS-2:0], PIN_IN[0]};
      if (pin0_s[1] == pin0_s[2])
        pin0_clean <= pin0_s[2];
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [31:0] ctrl;
  reg [PINS-1:0] polarity;
  reg [15:0] signature;
  reg fuse;
  reg locked;
  reg erased;
  reg prog_active;
  reg [1:0] phase;
  reg [7:0] init_cnt;
  reg [PTR_W-1:0] ptr;
  reg [31:0] cfg_mem [0:CFG_WORDS-1];
  integer i;

  wire wr = PSEL & PENABLE & PWRITE;
  wire setup = PSEL & ~PENABLE;
  wire mapped = hit(PADDR, `OFS_CTRL) | hit(PADDR, `OFS_STATUS) |
    hit(PADDR, `OFS_REDUCED_POWER) | hit(PADDR, `OFS_SLEW_FAST) |
    hit(PADDR, `OFS_SIGNATURE) | hit(PADDR, `OFS_CONFIG_DATA) |
    hit(PADDR, `OFS_PROG_CTRL) | hit(PADDR, `OFS_OUT_POLARITY);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  wire pd_option = ctrl[`CTRL_PD_OPTION];
  wire sleep_req = pd_option & (sleep_a | sleep_b); // R1
  wire jtag_en = ctrl[`CTRL_JTAG_EN];
  wire cmd = wr & hit(PADDR, `OFS_PROG_CTRL);
  wire start_ok = jtag_en & session & ~POWERED_DOWN; // R13

  // ----------------------------------------
  // power phase sequencer
  // ----------------------------------------
  always @(posedge CLK) begin
    if (SYS_RST) begin
      phase <= PH_INIT;
      init_cnt <= 8'h00;
    end else begin
      case (phase)
        PH_INIT: begin
          // clock assumed steady during reset, setup met after it // R9
          if (init_cnt == INIT_LAST)
            phase <= PH_RUN; // R7
          else
            init_cnt <= init_cnt + 8'h01;
        end
        PH_RUN: begin
          if (sleep_req)
            phase <= PH_DOWN; // R1
        end
        PH_DOWN: begin
          if (~sleep_a & ~sleep_b)
            phase <= PH_RUN; // R19
        end
        default: phase <= PH_INIT;
      endcase
    end
  end

  // ----------------------------------------
  // pin paths
  // ----------------------------------------
  wire down_next = (phase == PH_RUN) & sleep_req;
  always @(posedge CLK) begin
    if (SYS_RST) begin
      CORE_IN <= {PINS{1'b0}};
      JTAG_USER_IN <= 4'h0;
      PIN_OUT <= {PINS{1'b0}};
      PIN_OE <= {PINS{1'b0}};
      POWERED_DOWN <= 1'b0;
      KEEPER_ACTIVE <= 1'b0;
    end else begin
      POWERED_DOWN <= down_next | ((phase == PH_DOWN) & (sleep_a | sleep_b));
      KEEPER_ACTIVE <= ctrl[`CTRL_KEEPER_EN] & prog_active; // R16
      if (phase == PH_INIT) begin
        PIN_OUT <= polarity; // R7
        PIN_OE <= {PINS{1'b1}};
      end else if (locked) begin
        PIN_OE <= {PINS{1'b0}}; // R15
      end else if (prog_active & ctrl[`CTRL_KEEPER_EN]) begin
        PIN_OE <= PIN_OE; // R16
      end else if (prog_active) begin
        PIN_OE <= {PINS{1'b0}};
      end else if (phase == PH_RUN & ~down_next) begin
        PIN_OUT <= CORE_OUT;
        PIN_OE <= CORE_OE;
      end
      // held outputs and high impedance survive power-down // R2 R18
      if (phase == PH_RUN & ~down_next) begin
        // sleep pins are not logic inputs while the option is on // R4
        CORE_IN <= {pin_clean[PINS-1:1], pin0_clean & ~pd_option};
        if (~jtag_en)
          JTAG_USER_IN <= jtag_clean; // R14
      end
      // inputs frozen until sleep request falls // R3
    end
  end

  // ----------------------------------------
  // register writes and programming
  // ----------------------------------------
  always @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl <= `CTRL_RESET;
      CELL_REDUCED_POWER <= {CELLS{1'b0}};
      SLEW_FAST <= SLEW_INIT[PINS-1:0]; // R6
      polarity <= {PINS{1'b0}};
      signature <= `SIGNATURE_RESET;
      fuse <= 1'b0;
      locked <= 1'b0;
      erased <= 1'b1; // R17
      prog_active <= 1'b0;
      ptr <= {PTR_W{1'b0}};
      for (i = 0; i < CFG_WORDS; i = i + 1)
        cfg_mem[i] <= 32'h0000_0000;
    end else begin
      if (wr & hit(PADDR, `OFS_CTRL))
        ctrl <= PWDATA;
      if (wr & hit(PADDR, `OFS_REDUCED_POWER))
        CELL_REDUCED_POWER <= PWDATA[CELLS-1:0]; // R5
      if (wr & hit(PADDR, `OFS_SLEW_FAST))
        SLEW_FAST <= PWDATA[PINS-1:0]; // R6
      if (wr & hit(PADDR, `OFS_OUT_POLARITY))
        polarity <= PWDATA[PINS-1:0];
      if (wr & hit(PADDR, `OFS_SIGNATURE) & prog_active)
        signature <= PWDATA[15:0];
      if (wr & hit(PADDR, `OFS_CONFIG_DATA) & prog_active) begin
        cfg_mem[ptr] <= PWDATA; // R13
        ptr <= ptr + 1'b1;
        erased <= 1'b0;
      end else if (PSEL & PENABLE & ~PWRITE & hit(PADDR, `OFS_CONFIG_DATA)) begin
        ptr <= ptr + 1'b1;
      end
      if (cmd & PWDATA[`PROG_PTR_CLR])
        ptr <= {PTR_W{1'b0}};
      if (cmd & PWDATA[`PROG_START] & start_ok) begin
        prog_active <= 1'b1; // R13
        locked <= 1'b0;
      end else if (prog_active & (~session | ~jtag_en)) begin
        prog_active <= 1'b0;
        locked <= 1'b1; // R15
      end else if (cmd & PWDATA[`PROG_FINISH] & prog_active) begin
        prog_active <= 1'b0;
      end
      if (cmd & PWDATA[`PROG_FUSE] & prog_active)
        fuse <= 1'b1;
      if (cmd & PWDATA[`PROG_ERASE] & prog_active) begin
        fuse <= 1'b0;
        erased <= 1'b1;
        for (i = 0; i < CFG_WORDS; i = i + 1)
          cfg_mem[i] <= 32'h0000_0000;
      end
    end
  end

  always @(posedge CLK) begin
    if (SYS_RST) begin
      HYST_LARGE <= 1'b0;
      JTAG_PORT_ENABLED <= 1'b1;
    end else begin
      HYST_LARGE <= ctrl[`CTRL_HYST_LARGE]; // R10
      JTAG_PORT_ENABLED <= jtag_en; // R14
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0000_0000;
    if (hit(PADDR, `OFS_CTRL))
      next_rdata = {28'h000_0000, ctrl[3:0]};
    if (hit(PADDR, `OFS_STATUS)) begin
      next_rdata[`ST_POWERED_DOWN] = POWERED_DOWN;
      next_rdata[`ST_LOCKED] = locked;
      next_rdata[`ST_FUSE] = fuse;
      next_rdata[`ST_INIT_DONE] = (phase != PH_INIT);
      next_rdata[`ST_ERASED] = erased;
      next_rdata[`ST_PROG_ACTIVE] = prog_active;
    end
    if (hit(PADDR, `OFS_REDUCED_POWER))
      next_rdata[CELLS-1:0] = CELL_REDUCED_POWER;
    if (hit(PADDR, `OFS_SLEW_FAST))
      next_rdata[PINS-1:0] = SLEW_FAST;
    if (hit(PADDR, `OFS_OUT_POLARITY))
      next_rdata[PINS-1:0] = polarity;
    if (hit(PADDR, `OFS_SIGNATURE))
      next_rdata[15:0] = signature; // R12
    if (hit(PADDR, `OFS_CONFIG_DATA) & ~fuse)
      next_rdata = cfg_mem[ptr]; // R11
  end

  always @(posedge CLK) begin
    if (SYS_RST)
      PRDATA <= 32'h0000_0000;
    else if (setup & ~PWRITE)
      PRDATA <= next_rdata;
  end
endmodule // power_config_ctrl

// ### verilog/pwr_cfg_consts.vh
`ifndef PWR_CFG_CONSTS_VH
`define PWR_CFG_CONSTS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_REDUCED_POWER 8'h08
`define OFS_SLEW_FAST 8'h0C
`define OFS_SIGNATURE 8'h10
`define OFS_CONFIG_DATA 8'h14
`define OFS_PROG_CTRL 8'h18
`define OFS_OUT_POLARITY 8'h1C
// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_PD_OPTION 0
`define CTRL_HYST_LARGE 1
`define CTRL_JTAG_EN 2
`define CTRL_KEEPER_EN 3
`define CTRL_RESET 32'h0000_0004
// ----------------------------------------
// status fields
// ----------------------------------------
`define ST_POWERED_DOWN 0
`define ST_LOCKED 1
`define ST_FUSE 2
`define ST_INIT_DONE 3
`define ST_ERASED 4
`define ST_PROG_ACTIVE 5
// ----------------------------------------
// programming commands
// ----------------------------------------
`define PROG_START 0
`define PROG_FINISH 1
`define PROG_FUSE 2
`define PROG_ERASE 3
`define PROG_PTR_CLR 4
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define SIGNATURE_RESET 16'h0000
`define SLEW_RESET 32'h0000_0000
`define CLK_PERIOD_NS 40
`define INIT_DELAY_NS 400
`endif
